// file: verilog/pufl_defs.svh
// Offsets, field positions, reset values and status words of the command block.
`ifndef PUFL_DEFS_SVH
`define PUFL_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PUFL_OFF_CMD 8'h00
`define PUFL_OFF_KEY_LO 8'h04
`define PUFL_OFF_KEY_HI 8'h08
`define PUFL_OFF_NEWPIN_LO 8'h0C
`define PUFL_OFF_NEWPIN_HI 8'h10
`define PUFL_OFF_FILE_SEL 8'h14
`define PUFL_OFF_ACCESS 8'h18
`define PUFL_OFF_STATUS 8'h1C
`define PUFL_OFF_LIFECYCLE 8'h20
`define PUFL_OFF_PIN_LO 8'h24
`define PUFL_OFF_PIN_HI 8'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define PUFL_CMD_OP_LSB 0
`define PUFL_CMD_P1_LSB 8
`define PUFL_CMD_P2_LSB 16
`define PUFL_CMD_LC_LSB 24
`define PUFL_ACC_DISABLE_BIT 0
`define PUFL_ACC_REENABLE_BIT 1

// ****************************************************************
// Counts and reset values
// ****************************************************************
`define PUFL_KEY_TRIES 4'hA
`define PUFL_PIN_TRIES 2'h3
`define PUFL_LC_FULL 8'h10
`define PUFL_KEY_VALUE 64'h0000_0000_0000_0000
`define PUFL_PIN_RESET 64'h0000_0000_0000_0000
`define PUFL_FILE_BASE 16'h6F00
`define PUFL_DIR_FID 16'h7F00

// ****************************************************************
// Parameter one codes and status words
// ****************************************************************
`define PUFL_P1_BY_ID 8'h00
`define PUFL_P1_FROM_ROOT 8'h08
`define PUFL_P1_FROM_DIR 8'h09
`define PUFL_SW_OK 16'h9000
`define PUFL_SW_TRIES 12'h63C
`define PUFL_SW_BLOCKED 16'h6983
`define PUFL_SW_NO_ACCESS 16'h6982
`define PUFL_SW_NO_CURRENT 16'h6986
`define PUFL_SW_BAD_P1P2 16'h6A86
`define PUFL_SW_BAD_LEN 16'h6700
`define PUFL_SW_NOT_FOUND 16'h6A82
`define PUFL_SW_DEACTIVATED 16'h6283
`define PUFL_SW_BAD_OP 16'h6D00

`endif

// file: verilog/pufl_pkg.sv
// Types shared by the command block.
package pufl_pkg;

    typedef enum logic [1:0] {
        PUFL_OP_ACCESS = 2'h0,
        PUFL_OP_RECOVER = 2'h1,
        PUFL_OP_DISABLE = 2'h2,
        PUFL_OP_REENABLE = 2'h3
    } pufl_op_type;

    typedef struct packed {
        logic [7:0] lc;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [5:0] spare;
        pufl_op_type op;
    } pufl_cmd_type;

endpackage

// file: verilog/pufl_top.sv
// Pin recovery key and file life-cycle command block behind an AXI4-Lite slave.
`timescale 1ns/1ns
`default_nettype none
`include "pufl_defs.svh"
// Overview of operation
// - Recovery proceeds whether or not the pin is blocked, unless the key is blocked.
// - Correct key stores new pin, reloads key tries to 10, pin tries to 3.
// - Successful recovery enables the pin and satisfies its access level.
// - Wrong key decrements the single shared key retry counter.
// - First to ninth wrong keys answer 63C9 down to 63C1.
// - Tenth wrong key blocks the key and answers 63C0.
// - Later recovery attempts against a blocked key answer 6983.
// - Wrong key leaves pin enable, block and retry state untouched.
// - Empty data field only reports remaining key tries as 63CX.
// - Counter query against a blocked key answers 63C0.
// - Disable command reversibly deactivates a file and updates its life-cycle flag.
// - Disable runs only when the disable access condition is met.
// - Reenable reactivates a file when its access condition is met.
// - Successful disable or reenable makes that file the current file.
// - Failed disable or reenable leaves current file and directory unchanged.
// - Deactivated files refuse every operation except reenable, answering 6283.
// - Parameter one selects file id, path from root or path from directory.
// - Zero parameters with empty data apply the command to the current file.

module pufl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic session_restart,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ****************************************************************
    // State
    // ****************************************************************
    pufl_pkg::pufl_cmd_type cmd;
    logic cmd_go;
    logic [63:0] key_in;
    logic [63:0] new_pin;
    logic [31:0] file_sel;
    logic [1:0] access;
    logic [3:0] key_tries;
    logic key_blocked;
    logic [1:0] pin_tries;
    logic pin_enabled;
    logic pin_blocked;
    logic level_met;
    logic [63:0] pin_value;
    logic [7:0] deactivated;
    logic [2:0] cur_file;
    logic cur_valid;
    logic [15:0] status;

    // ****************************************************************
    // Write channel
    // ****************************************************************
    logic wr_fire;
    logic wr_hit;
    assign wr_fire = awready && awvalid && wready && wvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        unique case (awaddr)
            `PUFL_OFF_CMD, `PUFL_OFF_KEY_LO, `PUFL_OFF_KEY_HI, `PUFL_OFF_NEWPIN_LO,
            `PUFL_OFF_NEWPIN_HI, `PUFL_OFF_FILE_SEL, `PUFL_OFF_ACCESS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Ready is raised for one cycle only after both halves are offered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready <= awvalid && wvalid && !awready && !bvalid;
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= '0;
            cmd_go <= 1'b0;
            key_in <= '0;
            new_pin <= '0;
            file_sel <= '0;
            access <= 2'b00;
        end else begin
            cmd_go <= wr_fire && awaddr == `PUFL_OFF_CMD;
            if (wr_fire) begin
                unique case (awaddr)
                    `PUFL_OFF_CMD: cmd <= merge(cmd, wdata, wstrb);
                    `PUFL_OFF_KEY_LO: key_in[31:0] <= merge(key_in[31:0], wdata, wstrb);
                    `PUFL_OFF_KEY_HI: key_in[63:32] <= merge(key_in[63:32], wdata, wstrb);
                    `PUFL_OFF_NEWPIN_LO: new_pin[31:0] <= merge(new_pin[31:0], wdata, wstrb);
                    `PUFL_OFF_NEWPIN_HI: new_pin[63:32] <= merge(new_pin[63:32], wdata, wstrb);
                    `PUFL_OFF_FILE_SEL: file_sel <= merge(file_sel, wdata, wstrb);
                    `PUFL_OFF_ACCESS: access <= 2'(merge({30'h0, access}, wdata, wstrb));
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic is_recover;
    logic is_file;
    logic lc_empty;
    logic key_match;
    logic rec_wrong;
    logic rec_good;
    logic p1_legal;
    logic [15:0] fid_off;
    logic fid_found;
    logic path_ok;
    logic [2:0] target;
    logic target_ok;
    logic cond_met;
    logic file_success;

    assign is_recover = cmd_go && cmd.op == pufl_pkg::PUFL_OP_RECOVER;
    assign is_file = cmd_go && cmd.op != pufl_pkg::PUFL_OP_RECOVER;
    assign lc_empty = cmd.lc == 8'h00;
    assign key_match = key_in == `PUFL_KEY_VALUE;
    // Pin blocking is not looked at: only the key's own block gates the attempt.
    assign rec_good = is_recover && cmd.p1 == 8'h00 && cmd.lc == `PUFL_LC_FULL
                      && !key_blocked && key_match;
    assign rec_wrong = is_recover && cmd.p1 == 8'h00 && cmd.lc == `PUFL_LC_FULL
                       && !key_blocked && !key_match;
    assign p1_legal = cmd.p1 == `PUFL_P1_BY_ID || cmd.p1 == `PUFL_P1_FROM_ROOT
                      || cmd.p1 == `PUFL_P1_FROM_DIR;
    assign fid_off = file_sel[15:0] - `PUFL_FILE_BASE;
    assign fid_found = fid_off < 16'h0008;
    // All files live under one directory, so both path forms must name it first, in the upper half.
    assign path_ok = cmd.p1 == `PUFL_P1_BY_ID || file_sel[31:16] == `PUFL_DIR_FID;
    assign target = lc_empty ? cur_file : fid_off[2:0];
    assign target_ok = lc_empty ? (cur_valid && cmd.p1 == 8'h00) : (fid_found && path_ok);
    assign cond_met = cmd.op == pufl_pkg::PUFL_OP_DISABLE ? access[`PUFL_ACC_DISABLE_BIT]
                                                          : access[`PUFL_ACC_REENABLE_BIT];
    // Only reenable may touch a deactivated file; a repeated disable is refused so that
    // the file stays deactivated and the current file does not move.
    assign file_success = is_file && cmd.op != pufl_pkg::PUFL_OP_ACCESS && p1_legal
                          && cmd.p2 == 8'h00 && target_ok && cond_met
                          && !(cmd.op == pufl_pkg::PUFL_OP_DISABLE
                               && deactivated[target]);

    // ****************************************************************
    // Key and pin state
    // ****************************************************************
    // Counters are reloaded only by power-on reset or a correct key; a card session restart keeps them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_tries <= `PUFL_KEY_TRIES;
            key_blocked <= 1'b0;
            pin_tries <= `PUFL_PIN_TRIES;
            pin_enabled <= 1'b1;
            pin_blocked <= 1'b0;
            pin_value <= `PUFL_PIN_RESET;
            level_met <= 1'b0;
        end else if (rec_good) begin
            pin_value <= new_pin;
            key_tries <= `PUFL_KEY_TRIES;
            pin_tries <= `PUFL_PIN_TRIES;
            pin_blocked <= 1'b0;
            pin_enabled <= 1'b1;
            level_met <= 1'b1;
        end else if (rec_wrong) begin
            // A wrong key leaves every pin field alone, so guessing cannot lock the pin out.
            key_tries <= key_tries - 4'h1;
            key_blocked <= key_tries == 4'h1;
        end else if (session_restart) begin
            level_met <= 1'b0;
        end
    end

    // ****************************************************************
    // File state and status word
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deactivated <= 8'h00;
            cur_file <= 3'h0;
            cur_valid <= 1'b0;
        end else if (file_success) begin
            deactivated[target] <= cmd.op == pufl_pkg::PUFL_OP_DISABLE;
            cur_file <= target;
            cur_valid <= 1'b1;
        end else if (session_restart) begin
            cur_valid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= `PUFL_SW_OK;
        end else if (is_recover) begin
            if (cmd.p1 != 8'h00) begin
                status <= `PUFL_SW_BAD_P1P2;
            end else if (lc_empty) begin
                status <= {`PUFL_SW_TRIES, key_tries};
            end else if (cmd.lc != `PUFL_LC_FULL) begin
                status <= `PUFL_SW_BAD_LEN;
            end else if (key_blocked) begin
                status <= `PUFL_SW_BLOCKED;
            end else if (key_match) begin
                status <= `PUFL_SW_OK;
            end else begin
                status <= {`PUFL_SW_TRIES, key_tries - 4'h1};
            end
        end else if (is_file) begin
            if (!p1_legal || cmd.p2 != 8'h00) begin
                status <= `PUFL_SW_BAD_P1P2;
            end else if (lc_empty && !(cur_valid && cmd.p1 == 8'h00)) begin
                status <= `PUFL_SW_NO_CURRENT;
            end else if (!target_ok) begin
                status <= `PUFL_SW_NOT_FOUND;
            end else if (cmd.op != pufl_pkg::PUFL_OP_REENABLE && deactivated[target]) begin
                status <= `PUFL_SW_DEACTIVATED;
            end else if (cmd.op == pufl_pkg::PUFL_OP_ACCESS) begin
                status <= `PUFL_SW_OK;
            end else if (!cond_met) begin
                status <= `PUFL_SW_NO_ACCESS;
            end else begin
                status <= `PUFL_SW_OK;
            end
        end else if (cmd_go) begin
            status <= `PUFL_SW_BAD_OP;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        unique case (araddr)
            `PUFL_OFF_CMD: rd_word = cmd;
            `PUFL_OFF_FILE_SEL: rd_word = file_sel;
            `PUFL_OFF_ACCESS: rd_word = {30'h0, access};
            `PUFL_OFF_STATUS: rd_word = {2'b00, cur_valid, cur_file, level_met, pin_blocked,
                                         pin_enabled, pin_tries, key_blocked, key_tries, status};
            `PUFL_OFF_LIFECYCLE: rd_word = {24'h0, deactivated};
            `PUFL_OFF_PIN_LO: rd_word = pin_value[31:0];
            `PUFL_OFF_PIN_HI: rd_word = pin_value[63:32];
            `PUFL_OFF_KEY_LO, `PUFL_OFF_KEY_HI, `PUFL_OFF_NEWPIN_LO,
            `PUFL_OFF_NEWPIN_HI: rd_word = 32'h0000_0000;
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end else begin
            arready <= arvalid && !arready && !rvalid;
            if (arready && arvalid) begin
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_hit ? 2'b00 : 2'b10;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_good_key_reload: assert property (rec_good |=> key_tries == `PUFL_KEY_TRIES
        && pin_tries == `PUFL_PIN_TRIES && pin_value == $past(new_pin))
        else $error("Correct key did not reload counters and pin.");
    a_good_key_level: assert property (rec_good |=> pin_enabled && level_met
        && status == `PUFL_SW_OK)
        else $error("Correct key did not enable the pin.");
    a_wrong_key_count: assert property (rec_wrong |=> key_tries == $past(key_tries) - 4'h1
        && status == {`PUFL_SW_TRIES, $past(key_tries) - 4'h1})
        else $error("Wrong key did not count down with matching status.");
    a_tenth_blocks: assert property (rec_wrong && key_tries == 4'h1 |=> key_blocked
        && status == 16'h63C0)
        else $error("Tenth wrong key did not block.");
    a_blocked_refuses: assert property (is_recover && key_blocked && cmd.p1 == 8'h00
        && cmd.lc == `PUFL_LC_FULL |=> status == `PUFL_SW_BLOCKED && key_blocked)
        else $error("Blocked key did not answer 6983.");
    a_wrong_keeps_pin: assert property (rec_wrong |=> pin_tries == $past(pin_tries)
        && pin_enabled == $past(pin_enabled) && pin_blocked == $past(pin_blocked))
        else $error("Wrong key changed the pin state.");
    a_query_reports: assert property (is_recover && lc_empty && cmd.p1 == 8'h00
        |=> status == {`PUFL_SW_TRIES, $past(key_tries)} && key_tries == $past(key_tries))
        else $error("Counter query answered wrongly.");
    a_reserved_ignored: assert property (is_file && !p1_legal |=> status == `PUFL_SW_BAD_P1P2
        && deactivated == $past(deactivated) && cur_file == $past(cur_file))
        else $error("Reserved parameter one changed state.");
    a_no_cond_no_change: assert property (is_file && cmd.op != pufl_pkg::PUFL_OP_ACCESS
        && !cond_met |=> deactivated == $past(deactivated) && cur_file == $past(cur_file))
        else $error("File changed without its access condition.");
    a_success_selects: assert property (file_success ##1 1'b1 |-> cur_valid
        && cur_file == $past(target)
        && deactivated[cur_file] == ($past(cmd.op) == pufl_pkg::PUFL_OP_DISABLE))
        else $error("Successful file command did not select the file.");
    a_write_answer: assert property (wr_fire |=> bvalid && !awready && !wready)
        else $error("Write was not answered.");
    a_read_answer: assert property (arready && arvalid |=> rvalid && !arready)
        else $error("Read was not answered.");
    a_dead_file_kept: assert property (is_file && p1_legal && cmd.p2 == 8'h00 && target_ok
        && cmd.op == pufl_pkg::PUFL_OP_DISABLE && deactivated[target]
        |=> status == `PUFL_SW_DEACTIVATED && deactivated == $past(deactivated))
        else $error("Deactivated file accepted a disable.");
    a_session_keeps: assert property (session_restart && !rec_good && !rec_wrong
        |=> key_tries == $past(key_tries) && key_blocked == $past(key_blocked) && !level_met)
        else $error("Session restart disturbed the retry state.");
    a_blocked_stays: assert property (key_blocked |=> key_blocked)
        else $error("Blocked key became usable without power-on reset.");

    c_key_blocked: cover property (rec_wrong && key_tries == 4'h1);
    c_recovered: cover property (rec_good);
    c_disabled: cover property (file_success && cmd.op == pufl_pkg::PUFL_OP_DISABLE);
    c_reenabled: cover property (file_success && cmd.op == pufl_pkg::PUFL_OP_REENABLE);
    c_dead_refused: cover property (is_file && cmd.op == pufl_pkg::PUFL_OP_DISABLE && deactivated[target]);

endmodule // pufl_top
`default_nettype wire

// file: dv/pufl_term.sv
// Terminal model: an AXI4-Lite master that issues card commands to the block.
`timescale 1ns/1ns
`default_nettype none
`include "pufl_defs.svh"
module pufl_term (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'h0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'h0;
        bready = 1'h0;
        araddr = 8'h00;
        arvalid = 1'h0;
        rready = 1'h0;
    end
    // Address and data are offered together and each is dropped once its ready is seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
    endtask
    // Parameter two is always zero: it names pin zero for recovery and is fixed for files.
    task automatic send(input pufl_pkg::pufl_op_type op, input logic [7:0] p1,
                        input logic [7:0] lc, output logic [1:0] r);
        pufl_pkg::pufl_cmd_type c;
        c = '{lc: lc, p2: 8'h00, p1: p1, spare: 6'h00, op: op};
        wr(`PUFL_OFF_CMD, c, r);
    endtask
endmodule // pufl_term
`default_nettype wire

// file: dv/pufl_top_tb.sv
// Self-checking bench for the pin recovery key and file life-cycle block.
`timescale 1ns/1ns
`default_nettype none
`include "pufl_defs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module pufl_top_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic session_restart = 1'h0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, s;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [15:0] sw;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #10 aclk = ~aclk;
    pufl_top pufl_top_i (.aclk(aclk), .aresetn(aresetn), .session_restart(session_restart),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    pufl_term pufl_term_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    task automatic do_reset();
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    // Runs one command and returns the status word with the whole status register in s.
    task automatic run(input pufl_pkg::pufl_op_type op, input logic [7:0] p1, input logic [7:0] lc);
        pufl_term_i.send(op, p1, lc, r);
        pufl_term_i.rd(`PUFL_OFF_STATUS, s, r);
        sw = s[15:0];
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        pufl_term_i.wr(a, d, r);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        pufl_term_i.rd(`PUFL_OFF_STATUS, s, r);
        `CHK(s, 32'h00EA_9000)
        pufl_term_i.rd(8'h40, s, r);
        `CHK(r, 2'h2)
        pufl_term_i.wr(`PUFL_OFF_STATUS, 32'h0000_0000, r);
        `CHK(r, 2'h2)
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h00);
        `CHK(sw, 16'h63CA)
        $display("test reset and query done");
    endtask
    task automatic t_wrong();
        put(`PUFL_OFF_KEY_LO, 32'h0000_0001);
        for (int i = 1; i <= 9; i++) begin
            run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h10);
            `CHK(sw, {12'h63C, 4'(10 - i)})
            if (i == 5) begin
                session_restart <= 1'h1;
                @(posedge aclk);
                session_restart <= 1'h0;
            end
        end
        `CHK(s[23:21], 3'h7)
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h10);
        `CHK(sw, 16'h63C0)
        `CHK(s[20], 1'h1)
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h00);
        `CHK(sw, 16'h63C0)
        put(`PUFL_OFF_KEY_LO, 32'h0000_0000);
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h10);
        `CHK(sw, 16'h6983)
        $display("test wrong key done");
    endtask
    task automatic t_recover();
        do_reset();
        put(`PUFL_OFF_KEY_LO, 32'h0000_0100);
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h10);
        `CHK(sw, 16'h63C9)
        put(`PUFL_OFF_KEY_LO, 32'h0000_0000);
        put(`PUFL_OFF_NEWPIN_LO, 32'h9ABC_DEF0);
        put(`PUFL_OFF_NEWPIN_HI, 32'h1234_5678);
        run(pufl_pkg::PUFL_OP_RECOVER, 8'h00, 8'h10);
        `CHK(sw, 16'h9000)
        `CHK(s[25:16], 10'h2EA)
        pufl_term_i.rd(`PUFL_OFF_PIN_LO, s, r);
        `CHK(s, 32'h9ABC_DEF0)
        pufl_term_i.rd(`PUFL_OFF_PIN_HI, s, r);
        `CHK(s, 32'h1234_5678)
        $display("test recovery done");
    endtask
    task automatic t_files();
        put(`PUFL_OFF_ACCESS, 32'h0000_0000);
        put(`PUFL_OFF_FILE_SEL, 32'h0000_6F03);
        run(pufl_pkg::PUFL_OP_DISABLE, 8'h00, 8'h02);
        `CHK(sw, 16'h6982)
        `CHK(s[29], 1'h0)
        put(`PUFL_OFF_ACCESS, 32'h0000_0001);
        run(pufl_pkg::PUFL_OP_DISABLE, 8'h00, 8'h02);
        `CHK(sw, 16'h9000)
        `CHK(s[29:26], 4'hB)
        run(pufl_pkg::PUFL_OP_ACCESS, 8'h00, 8'h02);
        `CHK(sw, 16'h6283)
        run(pufl_pkg::PUFL_OP_DISABLE, 8'h00, 8'h02);
        `CHK(sw, 16'h6283)
        run(pufl_pkg::PUFL_OP_DISABLE, 8'h04, 8'h02);
        `CHK(sw, 16'h6A86)
        put(`PUFL_OFF_FILE_SEL, 32'h7F00_6F05);
        run(pufl_pkg::PUFL_OP_DISABLE, 8'h08, 8'h04);
        `CHK(sw, 16'h9000)
        `CHK(s[29:26], 4'hD)
        pufl_term_i.rd(`PUFL_OFF_LIFECYCLE, s, r);
        `CHK(s[7:0], 8'h28)
        put(`PUFL_OFF_FILE_SEL, 32'h7F01_6F03);
        run(pufl_pkg::PUFL_OP_REENABLE, 8'h09, 8'h04);
        `CHK(sw, 16'h6A82)
        `CHK(s[29:26], 4'hD)
        run(pufl_pkg::PUFL_OP_REENABLE, 8'h00, 8'h00);
        `CHK(sw, 16'h6982)
        put(`PUFL_OFF_ACCESS, 32'h0000_0003);
        run(pufl_pkg::PUFL_OP_REENABLE, 8'h00, 8'h00);
        `CHK(sw, 16'h9000)
        pufl_term_i.rd(`PUFL_OFF_LIFECYCLE, s, r);
        `CHK(s[7:0], 8'h08)
        $display("test files done");
    endtask
    initial begin
        do_reset();
        t_reset();
        t_wrong();
        t_recover();
        t_files();
        end_sim();
    end
endmodule // pufl_top_tb
`default_nettype wire
